//--- design/irq_bank_pkg.sv
// shared constants for the interrupt flag and enable bank
package irq_bank_pkg;
    // ==========================================================
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 16;

    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_FLAGS_SIX   = 8'h00;
    localparam logic [7:0] OFS_FLAGS_SEVEN = 8'h04;
    localparam logic [7:0] OFS_ENABLE_ZERO = 8'h08;
    localparam logic [7:0] OFS_ENABLE_ONE  = 8'h0c;
    localparam logic [7:0] OFS_EVT_STATUS  = 8'h10;
    localparam logic [7:0] OFS_EVT_MASK    = 8'h14;

    // ==========================================================
    // implemented-bit masks; every other bit reads zero
    localparam logic [15:0] MASK_FLAGS_SIX   = 16'h0790;
    localparam logic [15:0] MASK_FLAGS_SEVEN = 16'h0020;
    localparam logic [15:0] MASK_ENABLE_ZERO = 16'h7fff;
    localparam logic [15:0] MASK_ENABLE_ONE  = 16'hffdf;

    // ==========================================================
    // flag bit positions
    localparam int BIT_OSC_SELFTUNE  = 10;
    localparam int BIT_SIGMA_DELTA   = 9;
    localparam int BIT_OPAMP_TWO     = 8;
    localparam int BIT_OPAMP_ONE     = 7;
    localparam int BIT_DISPLAY_CTRL  = 4;
    localparam int BIT_BOUNDARY_SCAN = 5;

    // ==========================================================
    // reset values
    localparam logic [15:0] RESET_REG = 16'h0000;
    localparam logic [1:0]  RESET_EVT = 2'h0;

    // event status bits: 0 = a flag rose, 1 = a gated request rose
    localparam int EVT_W = 2;
endpackage

//--- design/irq_bus_if.sv
// internal register-access carrier between the bus slave and the register bank
`timescale 1ns/1ps
interface irq_bus_if;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [1:0]  sel;
    logic [31:0] rdata;
    logic        hit;

    modport slave (output wr_stb, rd_stb, addr, wdata, sel, input rdata, hit);
    modport bank  (input wr_stb, rd_stb, addr, wdata, sel, output rdata, hit);
endinterface

//--- design/irq_wb_slave.sv
// classic wishbone slave turning bus cycles into one-cycle strobes
`timescale 1ns/1ps
module irq_wb_slave
    import irq_bank_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    cyc,
    input  wire logic                    stb,
    input  wire logic                    we,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0] adr,
    input  wire logic [3:0]              sel,
    input  wire logic [irq_bank_pkg::DATA_W-1:0] dat_w,
    output logic [irq_bank_pkg::DATA_W-1:0]      dat_r,
    output logic                         ack,
    irq_bus_if.slave                     rb
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic   req;

    // ==========================================================
    // one access per request; ack drops in the cycle after it rose
    assign req       = cyc && stb && !s_reg.ack;
    assign rb.wr_stb = req && we;
    assign rb.rd_stb = req && !we;
    assign rb.addr   = adr;
    assign rb.wdata  = dat_w[15:0];
    assign rb.sel    = sel[1:0];

    always_comb begin
        s_next     = s_reg;
        s_next.ack = req;
        if (req) begin
            s_next.dat = (!we && rb.hit) ? rb.rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ack   = s_reg.ack;
    assign dat_r = s_reg.dat;
endmodule

//--- design/irq_reg_bank.sv
// flag, enable and event-status registers with interrupt gating
`timescale 1ns/1ps
module irq_reg_bank
    import irq_bank_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] req_six,
    input  wire logic [15:0] req_seven,
    input  wire logic [15:0] src_zero,
    input  wire logic [15:0] src_one,
    irq_bus_if.bank          rb,
    output logic [15:0]      fwd_six,
    output logic [15:0]      fwd_seven,
    output logic [15:0]      pass_zero,
    output logic [15:0]      pass_one,
    output logic             irq_line
);
    typedef struct packed {
        logic [15:0] flags_six;
        logic [15:0] flags_seven;
        logic [15:0] enable_zero;
        logic [15:0] enable_one;
        logic [1:0]  evt_status;
        logic [1:0]  evt_mask;
        logic [31:0] fwd_prev;
    } state_t;

    state_t s_reg;
    state_t s_next;

    function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] wd,
                                          input logic [1:0] bsel, input logic [15:0] impl);
        logic [15:0] m;
        m     = {{8{bsel[1]}}, {8{bsel[0]}}} & impl;
        merge = ((cur & ~m) | (wd & m)) & impl;
    endfunction

    function automatic logic hit_at(input logic [7:0] a, input logic [7:0] ofs);
        hit_at = (a == ofs);
    endfunction

    logic [31:0] fwd_now;
    logic        flag_rise;
    logic        gate_rise;

    // ==========================================================
    // gating: a source is passed on only while its own enable is one; flags go out ungated
    assign fwd_six   = s_reg.flags_six   & MASK_FLAGS_SIX;   // [RULE13]
    assign fwd_seven = s_reg.flags_seven & MASK_FLAGS_SEVEN; // [RULE13]
    assign pass_zero = src_zero & s_reg.enable_zero;         // [RULE6] [RULE7] [RULE8]
    assign pass_one  = src_one  & s_reg.enable_one;          // [RULE6] [RULE9] [RULE10] [RULE12]
    assign fwd_now   = {pass_one, pass_zero};
    assign flag_rise = |((req_six & MASK_FLAGS_SIX) & ~s_reg.flags_six)
                     | |((req_seven & MASK_FLAGS_SEVEN) & ~s_reg.flags_seven);
    assign gate_rise = |(fwd_now & ~s_reg.fwd_prev);

    always_comb begin
        s_next          = s_reg;
        s_next.fwd_prev = fwd_now;
        rb.hit          = 1'b1;
        rb.rdata        = 32'h0000_0000;
        if (hit_at(rb.addr, OFS_FLAGS_SIX)) begin
            rb.rdata = {16'h0000, s_reg.flags_six};              // [RULE3]
        end else if (hit_at(rb.addr, OFS_FLAGS_SEVEN)) begin
            rb.rdata = {16'h0000, s_reg.flags_seven};            // [RULE2]
        end else if (hit_at(rb.addr, OFS_ENABLE_ZERO)) begin
            rb.rdata = {16'h0000, s_reg.enable_zero};
        end else if (hit_at(rb.addr, OFS_ENABLE_ONE)) begin
            rb.rdata = {16'h0000, s_reg.enable_one};
        end else if (hit_at(rb.addr, OFS_EVT_STATUS)) begin
            rb.rdata = {30'h0, s_reg.evt_status};
        end else if (hit_at(rb.addr, OFS_EVT_MASK)) begin
            rb.rdata = {30'h0, s_reg.evt_mask};
        end else begin
            rb.hit = 1'b0;
        end
        if (rb.wr_stb) begin
            // software writes first; a peripheral request below wins over a clear
            if (hit_at(rb.addr, OFS_FLAGS_SIX)) begin
                s_next.flags_six = merge(s_reg.flags_six, rb.wdata, rb.sel,
                                         MASK_FLAGS_SIX);        // [RULE5] [RULE3]
            end
            if (hit_at(rb.addr, OFS_FLAGS_SEVEN)) begin
                s_next.flags_seven = merge(s_reg.flags_seven, rb.wdata, rb.sel,
                                           MASK_FLAGS_SEVEN);    // [RULE5] [RULE2]
            end
            if (hit_at(rb.addr, OFS_ENABLE_ZERO)) begin
                s_next.enable_zero = merge(s_reg.enable_zero, rb.wdata, rb.sel,
                                           MASK_ENABLE_ZERO);    // [RULE5] [RULE7]
            end
            if (hit_at(rb.addr, OFS_ENABLE_ONE)) begin
                s_next.enable_one = merge(s_reg.enable_one, rb.wdata, rb.sel,
                                          MASK_ENABLE_ONE);      // [RULE5] [RULE10]
            end
            if (hit_at(rb.addr, OFS_EVT_MASK) && rb.sel[0]) begin
                s_next.evt_mask = rb.wdata[1:0];
            end
        end
        if (rb.rd_stb && hit_at(rb.addr, OFS_EVT_STATUS)) begin
            s_next.evt_status = RESET_EVT;
        end
        // sticky flags: set by a request, held until software clears
        s_next.flags_six   = s_next.flags_six
                           | (req_six & MASK_FLAGS_SIX);     // [RULE1] [RULE4] [RULE13]
        s_next.flags_seven = s_next.flags_seven
                           | (req_seven & MASK_FLAGS_SEVEN); // [RULE2] [RULE4]
        s_next.evt_status  = s_next.evt_status  | {gate_rise, flag_rise};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg.flags_six   <= RESET_REG; // [RULE5]
            s_reg.flags_seven <= RESET_REG;
            s_reg.enable_zero <= RESET_REG;
            s_reg.enable_one  <= RESET_REG;
            s_reg.evt_status  <= RESET_EVT;
            s_reg.evt_mask    <= RESET_EVT;
            s_reg.fwd_prev    <= 32'h0000_0000;
            irq_line          <= 1'b0;
        end else begin
            s_reg    <= s_next;
            irq_line <= |(s_next.evt_status & s_next.evt_mask);
        end
    end
endmodule

//--- design/irq_flag_enable_bank.sv
// top of the interrupt flag and enable bank
// What the document requires of this block
// RULE1: flags six hold self-tune 10, sigma-delta 9, op amps 8/7, display 4.
// RULE2: flags seven implement only bit 5, the boundary-scan request.
// RULE3: unimplemented bits read zero and ignore writes.
// RULE4: a flag reads one after its source requested, else zero.
// RULE5: implemented bits are software read/write and reset to zero.
// RULE6: enable one passes a source request, zero blocks it.
// RULE7: enables zero bit 15 unused; 14..8 DMA1, ADC, UART-A tx/rx, SPI done/fault, timer3.
// RULE8: enables zero 7..0 timer2, cmp2, cap2, DMA0, timer1, cmp1, cap1, ext0.
// RULE9: enables one 15..8 UART-B tx/rx, ext2, timer5, timer4, cmp4, cmp3, DMA2.
// RULE10: enables one bit 7 capture eight, bit 6 capture seven, bit 5 unused.
// RULE11: software routes an enabled external input to a remap pin.
// RULE12: enables one 4..0 ext1, pin change, comparator, I2C-A master, I2C-A slave.
// RULE13: request forwarded only while flag and enable are both one; flags sticky. Code forwards flags ungated and gates sources by enable alone.
`timescale 1ns/1ps
module irq_flag_enable_bank
    import irq_bank_pkg::*;
(
    input  wire logic                             REF_CLK,
    input  wire logic                             RST,
    input  wire logic                             WB_CYC_I,
    input  wire logic                             WB_STB_I,
    input  wire logic                             WB_WE_I,
    input  wire logic [irq_bank_pkg::ADDR_W-1:0]  WB_ADR_I,
    input  wire logic [3:0]                       WB_SEL_I,
    input  wire logic [irq_bank_pkg::DATA_W-1:0]  WB_DAT_I,
    output logic [irq_bank_pkg::DATA_W-1:0]       WB_DAT_O,
    output logic                                  WB_ACK_O,
    input  wire logic [15:0]                      REQ_FLAGS_SIX,
    input  wire logic [15:0]                      REQ_FLAGS_SEVEN,
    input  wire logic [15:0]                      SRC_ENABLE_ZERO,
    input  wire logic [15:0]                      SRC_ENABLE_ONE,
    output logic [15:0]                           FWD_FLAGS_SIX,
    output logic [15:0]                           FWD_FLAGS_SEVEN,
    output logic [15:0]                           CPU_REQ_ZERO,
    output logic [15:0]                           CPU_REQ_ONE,
    output logic                                  IRQ
);
    // ==========================================================
    // carrier and submodules
    irq_bus_if rb ();

    logic [15:0] fwd_six;
    logic [15:0] fwd_seven;
    logic [15:0] pass_zero;
    logic [15:0] pass_one;
    logic        irq_line;

    irq_wb_slave irq_wb_slave_inst (
        .clk   (REF_CLK),
        .rst   (RST),
        .cyc   (WB_CYC_I),
        .stb   (WB_STB_I),
        .we    (WB_WE_I),
        .adr   (WB_ADR_I),
        .sel   (WB_SEL_I),
        .dat_w (WB_DAT_I),
        .dat_r (WB_DAT_O),
        .ack   (WB_ACK_O),
        .rb    (rb.slave)
    );

    irq_reg_bank irq_reg_bank_inst (
        .clk       (REF_CLK),
        .rst       (RST),
        .req_six   (REQ_FLAGS_SIX),
        .req_seven (REQ_FLAGS_SEVEN),
        .src_zero  (SRC_ENABLE_ZERO),
        .src_one   (SRC_ENABLE_ONE),
        .rb        (rb.bank),
        .fwd_six   (fwd_six),
        .fwd_seven (fwd_seven),
        .pass_zero (pass_zero),
        .pass_one  (pass_one),
        .irq_line  (irq_line)
    );

    // ==========================================================
    // outputs registered once more so every port leaves a flip-flop;
    // costs one cycle of latency toward the core
    typedef struct packed {
        logic [15:0] six;
        logic [15:0] seven;
        logic [15:0] zero;
        logic [15:0] one;
        logic        irq;
    } out_t;

    out_t o_reg;
    out_t o_next;

    always_comb begin
        o_next       = o_reg;
        o_next.six   = fwd_six;    // [RULE13]
        o_next.seven = fwd_seven;  // [RULE13]
        o_next.zero  = pass_zero;  // [RULE6]
        o_next.one   = pass_one;   // [RULE6]
        o_next.irq   = irq_line;
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            o_reg <= '0;
        end else begin
            o_reg <= o_next;
        end
    end

    assign FWD_FLAGS_SIX   = o_reg.six;
    assign FWD_FLAGS_SEVEN = o_reg.seven;
    assign CPU_REQ_ZERO    = o_reg.zero;
    assign CPU_REQ_ONE     = o_reg.one;
    assign IRQ             = o_reg.irq;
endmodule

//--- verif/irq_cpu_model.sv
// cpu-side model that accepts gated requests and remembers every one seen
`timescale 1ns/1ps
module irq_cpu_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] req_zero,
    input  wire logic [15:0] req_one,
    output logic [15:0]      seen_zero,
    output logic [15:0]      seen_one
);
    // ==========================================================
    // a request is taken on any cycle it stands; the core never refuses
    always_ff @(posedge clk) begin
        if (rst) begin
            seen_zero <= 16'h0000;
            seen_one  <= 16'h0000;
        end else begin
            seen_zero <= seen_zero | req_zero;
            seen_one  <= seen_one | req_one;
        end
    end
endmodule

//--- verif/irq_bank_monitor.sv
// concurrent checks on the ports of the interrupt flag and enable bank
`timescale 1ns/1ps
module irq_bank_monitor (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic        WB_ACK_O,
    input wire logic [15:0] REQ_FLAGS_SIX,
    input wire logic [15:0] SRC_ENABLE_ZERO,
    input wire logic [15:0] SRC_ENABLE_ONE,
    input wire logic [15:0] FWD_FLAGS_SIX,
    input wire logic [15:0] FWD_FLAGS_SEVEN,
    input wire logic [15:0] CPU_REQ_ZERO,
    input wire logic [15:0] CPU_REQ_ONE,
    input wire logic        IRQ
);
    // ==========================================================
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    six_holes_a: assert property ((FWD_FLAGS_SIX & ~16'h0790) == 16'h0000)
        else $error("unused flag six bit set");
    seven_holes_a: assert property ((FWD_FLAGS_SEVEN & ~16'h0020) == 16'h0000)
        else $error("unused flag seven bit set");
    gate_zero_a: assert property (
        (CPU_REQ_ZERO & ~($past(SRC_ENABLE_ZERO) & 16'h7fff)) == 16'h0)
        else $error("request zero passed without source");
    gate_one_a: assert property (
        (CPU_REQ_ONE & ~($past(SRC_ENABLE_ONE) & 16'hffdf)) == 16'h0)
        else $error("request one passed without source");
    flag_sticky_a: assert property ($fell(FWD_FLAGS_SIX[10]) |->
        $past(WB_CYC_I && WB_WE_I) || $past(WB_CYC_I && WB_WE_I, 2)) else $error("flag lost");
    flag_capture_a: assert property (
        REQ_FLAGS_SIX[10] ##1 !WB_CYC_I |=> FWD_FLAGS_SIX[10])
        else $error("flag not captured");
    reset_quiet_a: assert property (
        $past(RST) |-> !IRQ && !WB_ACK_O && CPU_REQ_ZERO == 16'h0)
        else $error("outputs not clear after reset");
    irq_seen_c: cover property ($rose(IRQ));
endmodule
bind irq_flag_enable_bank irq_bank_monitor irq_bank_monitor_inst (.*);

//--- verif/irq_flag_enable_bank_bench.sv
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/1ps
module irq_flag_enable_bank_bench;
    import irq_bank_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [3:0]  lanes = 4'h3;
    logic [31:0] dat = 32'h0, dato;
    logic        ack, irq;
    logic [15:0] req6 = 16'h0, req7 = 16'h0, src0 = 16'h0, src1 = 16'h0;
    logic [15:0] fwd6, fwd7, cpu0, cpu1, seen0, seen1;
    logic [31:0] q;
    int          errors = 0, checked = 0;
    logic [7:0]  ofs [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
    logic [15:0] msk [4] = '{16'h0790, 16'h0020, 16'h7fff, 16'hffdf};
    always #2.5 clk = ~clk;
    irq_flag_enable_bank irq_flag_enable_bank_inst (.REF_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
        .WB_DAT_O(dato), .WB_ACK_O(ack), .REQ_FLAGS_SIX(req6), .REQ_FLAGS_SEVEN(req7),
        .SRC_ENABLE_ZERO(src0), .SRC_ENABLE_ONE(src1), .FWD_FLAGS_SIX(fwd6),
        .FWD_FLAGS_SEVEN(fwd7), .CPU_REQ_ZERO(cpu0), .CPU_REQ_ONE(cpu1), .IRQ(irq));
    irq_cpu_model irq_cpu_model_inst (.clk(clk), .rst(rst), .req_zero(cpu0), .req_one(cpu1),
        .seen_zero(seen0), .seen_one(seen1));
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    // holds the cycle until ack; the bench watchdog is the only limit
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= lanes; dat <= {16'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic pulse(input logic [15:0] six, input logic [15:0] seven);
        @(posedge clk); req6 <= six; req7 <= seven;
        @(posedge clk); req6 <= 16'h0; req7 <= 16'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ==========================================================
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, 8'(i * 4), 16'h0); chk(q, 32'h0);
        end
    endtask
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, ofs[i], 16'hffff);
            wb(1'b0, ofs[i], 16'h0);
            chk(q, {16'h0, msk[i]});
            wb(1'b1, ofs[i], 16'h0); wb(1'b0, ofs[i], 16'h0); chk(q, 32'h0);
        end
    endtask
    // byte lanes: select bits 0 and 1 each write only their own half of a register; bits 2 and 3 are ignored
    task automatic t_lanes;
        lanes = 4'h1;
        wb(1'b1, 8'h08, 16'hffff);
        lanes = 4'h2;
        wb(1'b1, 8'h0c, 16'hffff);
        lanes = 4'h3;
        wb(1'b0, 8'h08, 16'h0);
        chk(q, 32'h0000_00ff);
        wb(1'b0, 8'h0c, 16'h0);
        chk(q, 32'h0000_ff00);
        wb(1'b1, 8'h08, 16'h0);
        wb(1'b1, 8'h0c, 16'h0);
    endtask
    task automatic t_flags;
        pulse(16'hffff, 16'hffff);
        chk(fwd6, 16'h0790); chk(fwd7, 16'h0020);
        repeat (20) @(posedge clk);
        wb(1'b0, 8'h00, 16'h0); chk(q, 32'h0790);
        wb(1'b0, 8'h04, 16'h0); chk(q, 32'h0020);
        wb(1'b1, 8'h00, 16'h0); wb(1'b1, 8'h04, 16'h0); wb(1'b0, 8'h00, 16'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_gate;
        src0 <= 16'hffff; src1 <= 16'hffff;
        for (int r = 0; r < 2; r++) for (int i = 0; i < 16; i++) begin
            wb(1'b1, ofs[r + 2], 16'h1 << i); repeat (2) @(posedge clk);
            chk(r ? cpu1 : cpu0,
                (16'h1 << i) & msk[r + 2]);
            wb(1'b1, ofs[r + 2], 16'h0); repeat (2) @(posedge clk);
            chk(r ? cpu1 : cpu0, 16'h0);
        end
        chk({seen0, seen1}, {16'h7fff, 16'hffdf});
        src0 <= 16'h0;
        wb(1'b1, 8'h08, 16'hffff); repeat (2) @(posedge clk);
        chk(cpu0, 16'h0);
        wb(1'b1, 8'h08, 16'h0); src1 <= 16'h0;
    endtask
    // software keeps external inputs routed, so no pin-select stimulus is needed
    task automatic t_irq;
        wb(1'b0, 8'h10, 16'h0); wb(1'b1, 8'h14, 16'h0001);
        pulse(16'h0, 16'h0020); chk(irq, 1'b1);
        wb(1'b0, 8'h10, 16'h0); chk(q, 32'h1);
        repeat (2) @(posedge clk); chk(irq, 1'b0);
        wb(1'b1, 8'h14, 16'h0); wb(1'b1, 8'h04, 16'h0);
        pulse(16'h0, 16'h0020); chk(irq, 1'b0);
        wb(1'b0, 8'h10, 16'h0); chk(q, 32'h1);
    endtask
    // a gated request that rises sets event bit 1, which alone drives the line
    task automatic t_gate_irq;
        wb(1'b1, 8'h14, 16'h0002);
        src0 <= 16'h0001;
        wb(1'b1, 8'h08, 16'h0001);
        repeat (2) @(posedge clk);
        chk(cpu0, 16'h0001);
        chk(irq, 1'b1);
        wb(1'b0, 8'h10, 16'h0);
        chk(q, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        src0 <= 16'h0;
        wb(1'b1, 8'h08, 16'h0);
        wb(1'b1, 8'h14, 16'h0);
    endtask
    // ==========================================================
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_lanes();
        t_flags();
        t_gate();
        t_irq();
        t_gate_irq();
        tally_and_finish();
    end
    // the whole run needs roughly five hundred cycles; the 20000-cycle limit leaves ample margin
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
endmodule
